/* common/flash_regs_pkg.sv */
`default_nettype none
package flash_regs_pkg;
	// Instruction codes seen on the serial input.
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] READ_STATUS_CMD = 8'h05;
	localparam logic [7:0] READ_CONFIG_CMD = 8'h15;
	localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
	localparam logic [7:0] ENTER_WIDE_ADDRESS_CMD = 8'hb7;
	localparam logic [7:0] EXIT_WIDE_ADDRESS_CMD = 8'he9;
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD = 8'h38;
	localparam logic [7:0] MINOR_BLOCK_WIPE_CMD = 8'h20;
	localparam logic [7:0] BLOCK_WIPE_32K_CMD = 8'h52;
	localparam logic [7:0] BLOCK_WIPE_64K_CMD = 8'hd8;
	localparam logic [7:0] CHIP_WIPE_CMD = 8'h60;
	localparam logic [7:0] CHIP_WIPE_ALT_CMD = 8'hc7;
	// Bit counts of a frame.
	localparam logic [7:0] OPCODE_BITS = 8'h08;
	localparam logic [7:0] SHORT_WRITE_BITS = 8'h10;
	localparam logic [7:0] LONG_WRITE_BITS = 8'h18;
	localparam logic [7:0] NARROW_ADDR_END = 8'h20;
	localparam logic [7:0] WIDE_ADDR_END = 8'h28;
	// Values after power-up.
	localparam logic [3:0] BLOCK_PROTECT_RESET = 4'h0;
	localparam logic [2:0] DRIVE_STRENGTH_RESET = 3'h7;
	localparam logic [1:0] DUMMY_CYCLE_RESET = 2'h0;
	// Self-timed status write cycle, and its length in system clocks.
	localparam int SYS_CLK_MHZ = 50;
	localparam int WRITE_CYCLE_NS = 10000;
	localparam int WRITE_CYCLE_CLKS = (WRITE_CYCLE_NS * SYS_CLK_MHZ + 999) / 1000;
	// Kinds of array operation handed to the array engine.
	typedef enum logic [2:0] {
		OP_PROGRAM = 3'h0,
		OP_QUAD_PROGRAM = 3'h1,
		OP_MINOR_WIPE = 3'h2,
		OP_WIPE_32K = 3'h3,
		OP_WIPE_64K = 3'h4,
		OP_CHIP_WIPE = 3'h5
	} array_op_t;
	// Status byte layout, bit 7 first.
	typedef struct packed {
		logic status_write_disable;
		logic quad_enable;
		logic [3:0] block_protect_level;
		logic write_enable_latch;
		logic busy_flag;
	} status_t;
	// Configuration byte layout, bit 7 first.
	typedef struct packed {
		logic [1:0] dummy_cycle_select;
		logic wide_address_flag;
		logic preamble_enable;
		logic top_bottom_select;
		logic [2:0] output_drive_strength;
	} config_t;
	// What the link side captured in the last frame.
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] bit_count;
		logic [31:0] payload;
	} frame_t;
endpackage
`default_nettype wire

/* logic/flash_status_config_regs.sv */
`default_nettype none
module flash_status_config_regs #(
	parameter int WRITE_CYCLES = flash_regs_pkg::WRITE_CYCLE_CLKS
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic link_sclk_i,
	input wire logic chip_select_n_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	input wire logic write_protect_pin_io2_i,
	input wire logic device_reset_n_i,
	input wire logic addr_protected_i,
	input wire logic array_done_i,
	output logic array_start_o,
	output flash_regs_pkg::array_op_t array_op_o,
	output logic [31:0] array_addr_o,
	output flash_regs_pkg::status_t status_o,
	output flash_regs_pkg::config_t config_o,
	output logic hardware_lock_state_o
);
	import flash_regs_pkg::*;

	initial begin
		if (WRITE_CYCLES < 1 || WRITE_CYCLES > 65535) begin
			$error("WRITE_CYCLES must lie in 1..65535");
		end
	end

	// Sequencer states; every state is one-hot.
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CHECK = 4'b0010,
		ST_WRITE_CYCLE = 4'b0100,
		ST_ARRAY_OP = 4'b1000
	} seq_state_t;

	// ---------------- Link domain, on the serial clock ----------------

	logic frame_open; // High from the first clock of a frame until chip select rises.
	frame_t frame; // Opcode, bit count and payload of the latest frame.
	logic [15:0] image_meta; // First synchroniser stage of the register image.
	logic [15:0] image_sync; // Second stage; the only copy the link logic reads.
	logic [7:0] tx_byte; // Byte being shifted out on reads.
	logic [2:0] tx_index; // Bit of tx_byte on the output.
	logic tx_active; // A read instruction is returning data.
	logic [7:0] next_opcode;
	logic [7:0] next_bit_count;
	logic [31:0] next_payload;
	logic [7:0] next_tx_byte;
	logic [2:0] next_tx_index;
	logic next_tx_active;
	logic [7:0] addr_end; // Payload stops shifting after the address.

	// Chip select high ends the frame at once, with no clock edge needed.
	always_ff @(posedge link_sclk_i or posedge chip_select_n_i) begin
		if (chip_select_n_i) begin
			frame_open <= 1'b0;
		end else begin
			frame_open <= 1'b1;
		end
	end

	// Receive bits and choose read data; the frame is kept after chip select rises
	// so the system side can take it while the serial clock stands still.
	always_comb begin
		addr_end = image_sync[13] ? WIDE_ADDR_END : NARROW_ADDR_END;
		next_bit_count = frame_open ? frame.bit_count : 8'h00;
		next_opcode = frame.opcode;
		next_payload = frame.payload;
		next_tx_byte = tx_byte;
		next_tx_index = tx_index - 3'h1;
		next_tx_active = frame_open & tx_active;
		if (next_bit_count < OPCODE_BITS) begin
			next_opcode = {next_opcode[6:0], serial_in_i};
		end else if (next_bit_count < addr_end) begin
			next_payload = {next_payload[30:0], serial_in_i};
		end
		if (next_bit_count == OPCODE_BITS - 8'h01) begin
			// Read-status is served even while busy, so the host can poll.
			next_tx_active = (next_opcode == READ_STATUS_CMD) ||
				(next_opcode == READ_CONFIG_CMD);
			next_tx_index = 3'h7;
		end
		if (next_tx_index == 3'h7) begin
			// Reload every byte so repeated reads show a fresh busy flag.
			next_tx_byte = (next_opcode == READ_CONFIG_CMD) ? image_sync[15:8] :
				image_sync[7:0];
		end
		if (next_bit_count != 8'hff) begin
			next_bit_count = next_bit_count + 8'h01;
		end
	end

	// Register the link-side state.
	always_ff @(posedge link_sclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame <= '0;
			image_meta <= '0;
			image_sync <= '0;
			tx_byte <= 8'h00;
			tx_index <= 3'h7;
			tx_active <= 1'b0;
		end else begin
			frame <= '{opcode: next_opcode, bit_count: next_bit_count, payload: next_payload};
			image_meta <= {config_o, status_o};
			image_sync <= image_meta;
			tx_byte <= next_tx_byte;
			tx_index <= next_tx_index;
			tx_active <= next_tx_active;
		end
	end

	// Drive data on the falling edge so the host samples it on the next rise.
	always_ff @(negedge link_sclk_i or posedge chip_select_n_i) begin
		if (chip_select_n_i) begin
			serial_out_o <= 1'b0;
			serial_out_oe_o <= 1'b0;
		end else begin
			serial_out_o <= tx_byte[tx_index];
			serial_out_oe_o <= tx_active;
		end
	end

	// ---------------- System domain ----------------

	logic cs_meta; // First stage of chip select; read only by cs_sync.
	logic cs_sync; // Synchronised chip select.
	logic cs_last; // Previous cs_sync, for the rising edge.
	logic wp_meta; // First stage of the protect pin.
	logic wp_sync; // Synchronised protect pin level.
	logic rst_meta; // First stage of the device reset pin.
	logic rst_sync_n; // Synchronised device reset pin, low while reset.
	seq_state_t state;
	seq_state_t next_state;
	status_t next_status;
	config_t next_config;
	logic next_lock;
	logic [15:0] wait_count; // Remaining clocks of a status write cycle.
	logic [15:0] next_wait_count;
	logic [15:0] pend_data; // Status byte high, config byte low.
	logic [15:0] next_pend_data;
	logic pend_long; // The pending write also carries the configuration byte.
	logic next_pend_long;
	logic next_array_start;
	array_op_t next_array_op;
	logic [31:0] next_array_addr;
	logic frame_end; // One pulse when chip select rises.
	logic [7:0] data_bits; // Bits after the opcode in the ended frame.
	logic is_array_cmd;
	logic is_quad_cmd;
	array_op_t decoded_op;

	// Two flip-flops for each pin level; the first stage feeds nothing else.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_last <= 1'b1;
			wp_meta <= 1'b1;
			wp_sync <= 1'b1;
			rst_meta <= 1'b1;
			rst_sync_n <= 1'b1;
		end else begin
			cs_meta <= chip_select_n_i;
			cs_sync <= cs_meta;
			cs_last <= cs_sync;
			wp_meta <= write_protect_pin_io2_i;
			wp_sync <= wp_meta;
			rst_meta <= device_reset_n_i;
			rst_sync_n <= rst_meta;
		end
	end

	// Decode of array instructions from the frame held on the link side.
	always_comb begin
		frame_end = cs_sync & ~cs_last;
		data_bits = frame.bit_count - OPCODE_BITS;
		is_array_cmd = 1'b1;
		is_quad_cmd = 1'b0;
		decoded_op = OP_PROGRAM;
		case (frame.opcode)
			PAGE_PROGRAM_CMD: begin
				decoded_op = OP_PROGRAM;
			end
			QUAD_PAGE_PROGRAM_CMD: begin
				decoded_op = OP_QUAD_PROGRAM;
				is_quad_cmd = 1'b1;
			end
			MINOR_BLOCK_WIPE_CMD: begin
				decoded_op = OP_MINOR_WIPE;
			end
			BLOCK_WIPE_32K_CMD: begin
				decoded_op = OP_WIPE_32K;
			end
			BLOCK_WIPE_64K_CMD: begin
				decoded_op = OP_WIPE_64K;
			end
			CHIP_WIPE_CMD, CHIP_WIPE_ALT_CMD: begin
				decoded_op = OP_CHIP_WIPE;
			end
			default: begin
				is_array_cmd = 1'b0;
			end
		endcase
	end

	// Sequencer and register next values.
	always_comb begin
		next_state = state;
		next_status = status_o;
		next_config = config_o;
		next_wait_count = wait_count;
		next_pend_data = pend_data;
		next_pend_long = pend_long;
		next_array_start = 1'b0;
		next_array_op = array_op_o;
		next_array_addr = array_addr_o;
		// Lock needs the disable bit and a low pin; quad mode turns it off.
		// Once locked, only a high pin or quad mode releases it.
		next_lock = hardware_lock_state_o;
		if (wp_sync || status_o.quad_enable) begin
			next_lock = 1'b0;
		end else if (status_o.status_write_disable) begin
			next_lock = 1'b1;
		end
		case (state)
			ST_IDLE: begin
				if (frame_end) begin
					case (frame.opcode)
						WRITE_ENABLE_CMD: begin
							next_status.write_enable_latch = 1'b1;
						end
						WRITE_DISABLE_CMD: begin
							next_status.write_enable_latch = 1'b0;
						end
						ENTER_WIDE_ADDRESS_CMD: begin
							next_config.wide_address_flag = 1'b1;
						end
						EXIT_WIDE_ADDRESS_CMD: begin
							next_config.wide_address_flag = 1'b0;
						end
						WRITE_STATUS_CMD: begin
							// Lengths other than 16 or 24 bits, a missing latch or lock refuse it.
							if (status_o.write_enable_latch && !hardware_lock_state_o &&
								(frame.bit_count == SHORT_WRITE_BITS ||
								frame.bit_count == LONG_WRITE_BITS)) begin
								next_pend_long = (frame.bit_count == LONG_WRITE_BITS);
								next_pend_data = next_pend_long ? frame.payload[15:0] :
									{frame.payload[7:0], 8'h00};
								next_wait_count = 16'(WRITE_CYCLES - 1);
								next_status.busy_flag = 1'b1;
								next_state = ST_WRITE_CYCLE;
							end
						end
						default: begin
							// Quad commands are ignored without quad enable.
							if (is_array_cmd && status_o.write_enable_latch &&
								(!is_quad_cmd || status_o.quad_enable) &&
								(data_bits >= 8'h18 || decoded_op == OP_CHIP_WIPE)) begin
								next_array_op = decoded_op;
								next_array_addr = config_o.wide_address_flag ?
									frame.payload : {8'h00, frame.payload[23:0]};
								next_state = ST_CHECK;
							end
						end
					endcase
				end
			end
			ST_CHECK: begin
				// The region map answers from array_addr_o, protect bits and the
				// top/bottom select in this cycle.
				if ((array_op_o == OP_CHIP_WIPE && status_o.block_protect_level != 4'h0) ||
					(array_op_o != OP_CHIP_WIPE && addr_protected_i)) begin
					next_status.write_enable_latch = 1'b0;
					next_state = ST_IDLE;
				end else begin
					next_array_start = 1'b1;
					next_status.busy_flag = 1'b1;
					next_state = ST_ARRAY_OP;
				end
			end
			ST_WRITE_CYCLE: begin
				if (wait_count == 16'h0000) begin
					// Data bits 1:0 are not written; busy and latch move by
					// the cycle alone.
					next_status.status_write_disable = pend_data[15];
					next_status.quad_enable = pend_data[14];
					next_status.block_protect_level = pend_data[13:10];
					if (pend_long) begin
						next_config.dummy_cycle_select = pend_data[7:6];
						next_config.preamble_enable = pend_data[4];
						// One-time bit: it can be set but never cleared.
						next_config.top_bottom_select = config_o.top_bottom_select |
							pend_data[3];
						next_config.output_drive_strength = pend_data[2:0];
					end
					next_status.busy_flag = 1'b0;
					next_status.write_enable_latch = 1'b0;
					next_state = ST_IDLE;
				end else begin
					next_wait_count = wait_count - 16'h0001;
				end
			end
			ST_ARRAY_OP: begin
				if (array_done_i) begin
					next_status.busy_flag = 1'b0;
					next_status.write_enable_latch = 1'b0;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// The reset pin restores the volatile bits and aborts any cycle; the
		// stored protection bits survive it, though power-up clears them.
		if (!rst_sync_n) begin
			next_state = ST_IDLE;
			next_status.busy_flag = 1'b0;
			next_status.write_enable_latch = 1'b0;
			next_config.output_drive_strength = DRIVE_STRENGTH_RESET;
			next_config.preamble_enable = 1'b0;
			next_config.wide_address_flag = 1'b0;
			next_config.dummy_cycle_select = DUMMY_CYCLE_RESET;
			next_array_start = 1'b0;
		end
	end

	// Power-up gives every bit its factory value.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			status_o <= '{status_write_disable: 1'b0, quad_enable: 1'b0,
				block_protect_level: BLOCK_PROTECT_RESET, write_enable_latch: 1'b0,
				busy_flag: 1'b0};
			config_o <= '{dummy_cycle_select: DUMMY_CYCLE_RESET, wide_address_flag: 1'b0,
				preamble_enable: 1'b0, top_bottom_select: 1'b0,
				output_drive_strength: DRIVE_STRENGTH_RESET};
			hardware_lock_state_o <= 1'b0;
			wait_count <= 16'h0000;
			pend_data <= 16'h0000;
			pend_long <= 1'b0;
			array_start_o <= 1'b0;
			array_op_o <= OP_PROGRAM;
			array_addr_o <= 32'h0000_0000;
		end else begin
			state <= next_state;
			status_o <= next_status;
			config_o <= next_config;
			hardware_lock_state_o <= next_lock;
			wait_count <= next_wait_count;
			pend_data <= next_pend_data;
			pend_long <= next_pend_long;
			array_start_o <= next_array_start;
			array_op_o <= next_array_op;
			array_addr_o <= next_array_addr;
		end
	end
endmodule
`default_nettype wire

/* tb/flash_status_config_regs_asserts.sv */
`default_nettype none
module flash_status_config_regs_asserts #(
	parameter int WRITE_CYCLES = flash_regs_pkg::WRITE_CYCLE_CLKS
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic addr_protected_i,
	input wire logic array_start_o,
	input wire flash_regs_pkg::array_op_t array_op_o,
	input wire flash_regs_pkg::status_t status_o,
	input wire flash_regs_pkg::config_t config_o,
	input wire logic hardware_lock_state_o
);
	import flash_regs_pkg::*;
	// Every check lives in the system clock domain and sleeps through reset.
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// A start is only legal if the latch was set when the request was checked.
	a_start_needs_wel: assert property (array_start_o |-> $past(status_o.write_enable_latch))
		else $error("array start without write enable");
	// The busy flag must already show the operation that was just launched.
	a_start_sets_busy: assert property (array_start_o |-> status_o.busy_flag)
		else $error("array start without busy");
	// Whatever ends a busy period also drops the latch on the same edge.
	a_end_clears_wel: assert property ($fell(status_o.busy_flag) |-> !status_o.write_enable_latch)
		else $error("busy ended with latch still set");
	// The latch must stand for the whole of a busy period.
	a_wel_while_busy: assert property (status_o.busy_flag |-> status_o.write_enable_latch)
		else $error("latch lost during busy");
	// A region hit seen in the check cycle must block every non-chip start.
	a_protect_no_start: assert property ((array_start_o && array_op_o != OP_CHIP_WIPE) |->
		!$past(addr_protected_i)) else $error("start into protected region");
	// Chip wipe is only allowed with no level set.
	a_chip_wipe_bp: assert property ((array_start_o && array_op_o == OP_CHIP_WIPE) |->
		status_o.block_protect_level == 4'h0) else $error("chip wipe with protect set");
	// Quad programming needs quad mode on.
	a_quad_needs_qe: assert property ((array_start_o && array_op_o == OP_QUAD_PROGRAM) |->
		status_o.quad_enable) else $error("quad start with quad mode off");
	// While locked the disable bit and the levels must not move.
	a_lock_freezes: assert property (hardware_lock_state_o ##1 hardware_lock_state_o |->
		$stable(status_o.block_protect_level) && $stable(status_o.status_write_disable))
		else $error("protect bits changed while locked");
	// The lock only exists with the disable bit set and quad mode off.
	a_lock_cause: assert property (hardware_lock_state_o |->
		status_o.status_write_disable && !status_o.quad_enable) else $error("lock without cause");
	// The one-time select never returns to zero once set.
	a_tb_one_time: assert property ($past(config_o.top_bottom_select) |->
		config_o.top_bottom_select) else $error("top bottom select cleared");
endmodule
bind flash_status_config_regs flash_status_config_regs_asserts #(
	.WRITE_CYCLES(WRITE_CYCLES)
) i_asserts (
	.sys_clk_i(sys_clk_i),
	.sys_rst_i(sys_rst_i),
	.addr_protected_i(addr_protected_i),
	.array_start_o(array_start_o),
	.array_op_o(array_op_o),
	.status_o(status_o),
	.config_o(config_o),
	.hardware_lock_state_o(hardware_lock_state_o)
);
`default_nettype wire

/* tb/host_spi_model.sv */
`default_nettype none
module host_spi_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// Mode 0 host: the clock rests low and stands still between frames.
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// Sends the low n bits of tx MSB first; rx keeps the last byte seen on the data output.
	// Callers end write-status frames on a byte boundary unless refusal is wanted.
	task automatic frame(input logic [39:0] tx, input int n, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		cs_n_o = 1'b0;
		for (i = n - 1; i >= 0; i--) begin
			si_o = tx[i];
			#62.5 sclk_o = 1'b1;
			rx = {rx[6:0], so_i};
			#62.5 sclk_o = 1'b0;
		end
		// The line is no longer held, so show a changed level rather than the last bit.
		si_o = ~si_o;
		#62.5 cs_n_o = 1'b1;
		// Deselect long enough for the gap, the crossing and a short write cycle.
		#500;
	endtask
endmodule
`default_nettype wire

/* tb/flash_status_config_regs_tb.sv */
`default_nettype none
module flash_status_config_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import flash_regs_pkg::*;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic sclk, cs_n, si, so, so_oe, start, lock;
	logic wp_pin = 1'b1;
	logic dev_rst_n = 1'b1;
	logic prot = 1'b0;
	logic done = 1'b0;
	array_op_t op, last_op;
	logic [31:0] addr, last_addr;
	status_t status;
	config_t cfg;
	logic [7:0] starts = 8'h00; // Array starts seen since time zero; the count is never cleared.
	logic [7:0] rx;
	logic oe_seen = 1'b0; // Set when the device drove the data line during a frame.
	int fails = 0;
	int checks_done = 0;
	// System clock, 20 ns period.
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	flash_status_config_regs #(.WRITE_CYCLES(4)) i_flash_status_config_regs (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link_sclk_i(sclk),
		.chip_select_n_i(cs_n), .serial_in_i(si), .serial_out_o(so), .serial_out_oe_o(so_oe),
		.write_protect_pin_io2_i(wp_pin), .device_reset_n_i(dev_rst_n),
		.addr_protected_i(prot), .array_done_i(done), .array_start_o(start),
		.array_op_o(op), .array_addr_o(addr), .status_o(status), .config_o(cfg),
		.hardware_lock_state_o(lock));
	host_spi_model i_host_spi_model (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
	// Records each start with the kind and address it carried.
	always @(posedge sys_clk_i) begin
		if (start === 1'b1) begin
			starts <= starts + 8'h01;
			last_op <= op;
			last_addr <= addr;
		end
	end
	// The enable is launched on the falling edge, so it is settled at each rise.
	always @(posedge sclk) begin
		if (so_oe === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Every frame starts one fixed step after a system clock edge.
	task automatic cmd(input logic [39:0] tx, input int n);
		@(posedge sys_clk_i);
		#1;
		i_host_spi_model.frame(tx, n, rx);
	endtask
	// Reads one register byte, compares the masked value and checks the enable.
	task automatic rd(input logic [7:0] opc, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge sys_clk_i);
		#1;
		oe_seen = 1'b0;
		i_host_spi_model.frame({24'h0, opc, 8'h00}, 16, rx);
		chk({24'h0, rx & mask}, {24'h0, exp});
		chk({31'h0, oe_seen}, 32'h1);
		chk({31'h0, so_oe}, 32'h0);
	endtask
	task automatic write_enable_cmd();
		cmd({32'h0, WRITE_ENABLE_CMD}, 8);
	endtask
	// Plays the array engine: one finish pulse, then time for the flags to settle.
	task automatic finish_op();
		@(posedge sys_clk_i);
		#1 done = 1'b1;
		@(posedge sys_clk_i);
		#1 done = 1'b0;
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic tend(input string name);
		$display("test %s finished", name);
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// A hung run is cut short and counted as a mismatch.
	initial begin
		#2000000;
		fails++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		repeat (4) @(posedge sys_clk_i);
		#3.7;
		rd(READ_STATUS_CMD, 8'hff, 8'h00);
		rd(READ_CONFIG_CMD, 8'hff, 8'h07);
		tend("reset values");
		cmd({8'h0, PAGE_PROGRAM_CMD, 24'h123456}, 32);
		chk(starts, 8'h00);
		write_enable_cmd();
		rd(READ_STATUS_CMD, 8'hff, 8'h02);
		cmd({8'h0, PAGE_PROGRAM_CMD, 24'h123456}, 32);
		chk({starts, 21'h0, last_op}, {8'h01, 21'h0, OP_PROGRAM});
		chk(last_addr, 32'h00123456);
		rd(READ_STATUS_CMD, 8'hff, 8'h03);
		finish_op();
		rd(READ_STATUS_CMD, 8'hff, 8'h00);
		tend("program");
		prot = 1'b1;
		write_enable_cmd();
		cmd({8'h0, MINOR_BLOCK_WIPE_CMD, 24'h001000}, 32);
		chk(starts, 8'h01);
		rd(READ_STATUS_CMD, 8'hff, 8'h00);
		prot = 1'b0;
		tend("protected target");
		write_enable_cmd();
		cmd({16'h0, WRITE_STATUS_CMD, 8'h3f, 8'hfd}, 24);
		rd(READ_STATUS_CMD, 8'hff, 8'h3c);
		rd(READ_CONFIG_CMD, 8'hff, 8'hdd);
		write_enable_cmd();
		cmd({32'h0, CHIP_WIPE_CMD}, 8);
		chk(starts, 8'h01);
		rd(READ_STATUS_CMD, 8'hff, 8'h3c);
		tend("status write and chip refusal");
		write_enable_cmd();
		cmd({20'h0, WRITE_STATUS_CMD, 12'h000}, 20);
		rd(READ_STATUS_CMD, 8'hfc, 8'h3c);
		write_enable_cmd();
		cmd({24'h0, WRITE_STATUS_CMD, 8'h00}, 16);
		rd(READ_STATUS_CMD, 8'hff, 8'h00);
		rd(READ_CONFIG_CMD, 8'hff, 8'hdd);
		write_enable_cmd();
		cmd({16'h0, WRITE_STATUS_CMD, 16'h0000}, 24);
		rd(READ_CONFIG_CMD, 8'hff, 8'h08);
		write_enable_cmd();
		cmd({32'h0, CHIP_WIPE_ALT_CMD}, 8);
		chk({starts, 21'h0, last_op}, {8'h02, 21'h0, OP_CHIP_WIPE});
		finish_op();
		tend("write lengths and chip wipe");
		cmd({32'h0, ENTER_WIDE_ADDRESS_CMD}, 8);
		rd(READ_CONFIG_CMD, 8'hff, 8'h28);
		write_enable_cmd();
		cmd({PAGE_PROGRAM_CMD, 32'h89abcdef}, 40);
		chk(last_addr, 32'h89abcdef);
		finish_op();
		cmd({32'h0, EXIT_WIDE_ADDRESS_CMD}, 8);
		rd(READ_CONFIG_CMD, 8'hff, 8'h08);
		tend("address mode");
		write_enable_cmd();
		cmd({8'h0, QUAD_PAGE_PROGRAM_CMD, 24'h000100}, 32);
		chk(starts, 8'h03);
		write_enable_cmd();
		cmd({16'h0, WRITE_STATUS_CMD, 16'h4008}, 24);
		write_enable_cmd();
		cmd({8'h0, QUAD_PAGE_PROGRAM_CMD, 24'h000100}, 32);
		chk({starts, 21'h0, last_op}, {8'h04, 21'h0, OP_QUAD_PROGRAM});
		finish_op();
		tend("quad mode");
		wp_pin = 1'b0;
		write_enable_cmd();
		cmd({16'h0, WRITE_STATUS_CMD, 16'h8008}, 24);
		chk({31'h0, lock}, 32'h1);
		write_enable_cmd();
		cmd({16'h0, WRITE_STATUS_CMD, 16'h0408}, 24);
		rd(READ_STATUS_CMD, 8'hfc, 8'h80);
		wp_pin = 1'b1;
		repeat (6) @(posedge sys_clk_i);
		#1;
		chk({31'h0, lock}, 32'h0);
		write_enable_cmd();
		cmd({16'h0, WRITE_STATUS_CMD, 16'h04dd}, 24);
		rd(READ_STATUS_CMD, 8'hff, 8'h04);
		tend("hardware lock");
		#1 dev_rst_n = 1'b0;
		repeat (5) @(posedge sys_clk_i);
		#1 dev_rst_n = 1'b1;
		repeat (5) @(posedge sys_clk_i);
		rd(READ_CONFIG_CMD, 8'hff, 8'h0f);
		rd(READ_STATUS_CMD, 8'hff, 8'h04);
		tend("device reset");
		test_done();
	end
endmodule
`default_nettype wire
